// ===== hw/tpw_pkg.sv
// Shared constants and types of the triple 16-bit pulse-width modulator.
package tpw_pkg;

  localparam int unsigned CH_NUM      = 3;
  localparam int unsigned CNT_W       = 16;

  // Register indices; byte address is four times the index.
  localparam logic [7:0]  IDX_CLK_SEL = 8'hA1;
  localparam logic [7:0]  IDX_CTRL    = 8'hA7;
  localparam logic [7:0]  IDX_IRQ_EN  = 8'hA9;
  localparam logic [7:0]  IDX_FLAGS   = 8'h86;
  localparam logic [7:0]  IDX_CH_BASE = 8'hD1;
  localparam logic [7:0]  CH_STRIDE   = 8'h04;
  localparam logic [7:0]  OFS_DUTY_HI = 8'h00;
  localparam logic [7:0]  OFS_DUTY_LO = 8'h01;
  localparam logic [7:0]  OFS_PER_HI  = 8'h02;
  localparam logic [7:0]  OFS_PER_LO  = 8'h03;

  // Field positions.
  localparam int unsigned CTRL_CLR_LSB  = 0;
  localparam int unsigned CTRL_IE_LSB   = 4;
  localparam int unsigned IRQ_EN_GLOBAL = 7;
  localparam int unsigned CKS_W         = 2;

  // Reset values.
  localparam logic [7:0]  CLK_SEL_RST = 8'h2A;
  localparam logic [15:0] DUTY_RST    = 16'h8000;
  localparam logic [15:0] PERIOD_RST  = 16'hFFFF;

  typedef enum logic [1:0] {
    TPW_CKS_SYS_A = 2'b00,
    TPW_CKS_SYS_B = 2'b01,
    TPW_CKS_FRC   = 2'b10,
    TPW_CKS_FRC2  = 2'b11
  } tpw_cks_e;

  typedef enum logic [1:0] {
    TPW_BUS_IDLE  = 2'b00,
    TPW_BUS_FETCH = 2'b01,
    TPW_BUS_DONE  = 2'b10
  } tpw_bus_e;

endpackage

// ===== hw/tpw_channel.sv
// One modulator channel: base counter, active period and duty, output level.
`timescale 1ns/100ps
`default_nettype none

module tpw_channel #(
  parameter int unsigned CNT_W = 16
) (
  // Clock, reset, enable
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  // Control
  input  wire logic             tick_in,
  input  wire logic             clear_in,
  input  wire logic [CNT_W-1:0] period_in,
  input  wire logic [CNT_W-1:0] duty_in,
  // Results
  output logic                  pwm_out,
  output logic                  period_end_out
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] per;
    logic [CNT_W-1:0] duty;
    logic             out;
  } tpw_ch_s;

  localparam tpw_ch_s CH_RST = '{
    cnt:  '0,
    per:  CNT_W'(tpw_pkg::PERIOD_RST),
    duty: CNT_W'(tpw_pkg::DUTY_RST),
    out:  1'b1
  };

  tpw_ch_s s_q;
  tpw_ch_s s_d;

  always_comb begin
    s_d            = s_q;
    period_end_out = 1'b0;
    if (clear_in) begin
      // Held at zero with the shadow values loaded straight through.
      s_d.cnt  = '0;
      s_d.per  = period_in;
      s_d.duty = duty_in;
      s_d.out  = 1'b0;
    end else if (tick_in) begin
      if (s_q.cnt == s_q.per) begin
        s_d.cnt        = '0;
        s_d.per        = period_in;
        s_d.duty       = duty_in;
        s_d.out        = (duty_in != '0);
        period_end_out = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + CNT_W'(1);
        if (s_d.cnt == s_q.duty) begin
          s_d.out = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= CH_RST;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  assign pwm_out = s_q.out;

endmodule

`default_nettype wire

// ===== hw/tpw_triple_pwm.sv
// Three independent 16-bit pulse-width modulators behind an AHB-Lite slave.
`timescale 1ns/100ps
`default_nettype none

module tpw_triple_pwm #(
  parameter int unsigned CH_NUM = tpw_pkg::CH_NUM,
  parameter int unsigned CNT_W  = tpw_pkg::CNT_W
) (
  // Clock, reset, enable
  input  wire logic              SYS_CLK_IN,
  input  wire logic              RST_B_IN,
  input  wire logic              CE_IN,
  // Slow oscillator, sampled as a pin
  input  wire logic              FRC_CLK_IN,
  // AHB-Lite slave
  input  wire logic              HSEL_IN,
  input  wire logic [31:0]       HADDR_IN,
  input  wire logic [1:0]        HTRANS_IN,
  input  wire logic              HWRITE_IN,
  input  wire logic [2:0]        HSIZE_IN,
  input  wire logic [31:0]       HWDATA_IN,
  input  wire logic              HREADY_IN,
  output logic      [31:0]       HRDATA_OUT,
  output logic                   HREADYOUT_OUT,
  output logic                   HRESP_OUT,
  // Modulated outputs and interrupt
  output logic      [CH_NUM-1:0] PWM_OUT,
  output logic                   IRQ_OUT
);

  typedef struct packed {
    tpw_pkg::tpw_bus_e               bus;
    logic [7:0]                      addr;
    logic                            wr_pend;
    logic [7:0]                      rdata;
    logic [CH_NUM*2-1:0]             clk_sel;
    logic [CH_NUM-1:0]               clr;
    logic [CH_NUM-1:0]               ch_ie;
    logic                            gie;
    logic [CH_NUM-1:0]               flags;
    logic [7:0]                      latch;
    logic [CH_NUM-1:0][CNT_W-1:0]    duty_sh;
    logic [CH_NUM-1:0][CNT_W-1:0]    per_sh;
    logic                            frc_s1;
    logic                            frc_s2;
    logic                            frc_prev;
  } tpw_top_s;

  localparam tpw_top_s TOP_RST = '{
    bus:      tpw_pkg::TPW_BUS_IDLE,
    addr:     8'h00,
    wr_pend:  1'b0,
    rdata:    8'h00,
    clk_sel:  (CH_NUM*2)'(tpw_pkg::CLK_SEL_RST),
    clr:      '0,
    ch_ie:    '0,
    gie:      1'b0,
    flags:    '0,
    latch:    8'h00,
    duty_sh:  {CH_NUM{CNT_W'(tpw_pkg::DUTY_RST)}},
    per_sh:   {CH_NUM{CNT_W'(tpw_pkg::PERIOD_RST)}},
    frc_s1:   1'b0,
    frc_s2:   1'b0,
    frc_prev: 1'b0
  };

  logic [1:0]        rst_sync_q;
  logic              rst_n;
  tpw_top_s          s_q;
  tpw_top_s          s_d;
  logic [CH_NUM-1:0] tick;
  logic [CH_NUM-1:0] period_end;
  logic [CH_NUM-1:0] pwm;
  logic              frc_rise;
  logic              frc_edge;

  // Reset is released through two flip-flops so the state and channel registers leave reset together.
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // The oscillator is far slower than the system clock, so its edges become ticks.
  // Doubling uses both edges; the duty ratio of the oscillator then sets the jitter.
  assign frc_rise = s_q.frc_s2 & ~s_q.frc_prev;
  assign frc_edge = s_q.frc_s2 ^ s_q.frc_prev;

  always_comb begin
    for (int c = 0; c < CH_NUM; c++) begin
      case (tpw_pkg::tpw_cks_e'(s_q.clk_sel[c*2 +: 2]))
        tpw_pkg::TPW_CKS_SYS_A: tick[c] = 1'b1;
        tpw_pkg::TPW_CKS_SYS_B: tick[c] = 1'b1;
        tpw_pkg::TPW_CKS_FRC:   tick[c] = frc_rise;
        tpw_pkg::TPW_CKS_FRC2:  tick[c] = frc_edge;
        default:                tick[c] = 1'b1;
      endcase
    end
  end

  always_comb begin
    logic [7:0] base;
    logic [7:0] val;
    logic [7:0] wdata;
    logic       take;
    s_d   = s_q;
    base  = 8'h00;
    val   = 8'h00;
    wdata = HWDATA_IN[7:0];
    take  = HSEL_IN & HREADY_IN & HTRANS_IN[1];

    s_d.frc_s1   = FRC_CLK_IN;
    s_d.frc_s2   = s_q.frc_s1;
    s_d.frc_prev = s_q.frc_s2;

    // Hardware sets win over a clearing write in the same cycle.
    s_d.flags = s_q.flags | period_end;

    // Write data phase; registers are updated without wait states.
    if (s_q.wr_pend) begin
      s_d.wr_pend = 1'b0;
      case (s_q.addr)
        tpw_pkg::IDX_CLK_SEL: s_d.clk_sel = wdata[CH_NUM*2-1:0];
        tpw_pkg::IDX_CTRL: begin
          s_d.clr   = wdata[tpw_pkg::CTRL_CLR_LSB +: CH_NUM];
          s_d.ch_ie = wdata[tpw_pkg::CTRL_IE_LSB +: CH_NUM];
        end
        tpw_pkg::IDX_IRQ_EN: s_d.gie = wdata[tpw_pkg::IRQ_EN_GLOBAL];
        tpw_pkg::IDX_FLAGS: begin
          s_d.flags = (s_q.flags & wdata[CH_NUM-1:0]) | period_end;
        end
        default: begin
          for (int c = 0; c < CH_NUM; c++) begin
            base = tpw_pkg::IDX_CH_BASE + 8'(c) * tpw_pkg::CH_STRIDE;
            if (s_q.addr == base + tpw_pkg::OFS_DUTY_LO ||
                s_q.addr == base + tpw_pkg::OFS_PER_LO) begin
              s_d.latch = wdata;
            end
            if (s_q.addr == base + tpw_pkg::OFS_DUTY_HI) begin
              s_d.duty_sh[c] = CNT_W'({wdata, s_q.latch});
            end
            if (s_q.addr == base + tpw_pkg::OFS_PER_HI) begin
              s_d.per_sh[c] = CNT_W'({wdata, s_q.latch});
            end
          end
        end
      endcase
    end

    // Read path: one wait state so read data leave a flip-flop.
    case (s_q.bus)
      tpw_pkg::TPW_BUS_IDLE: begin
        s_d.bus = tpw_pkg::TPW_BUS_IDLE;
      end
      tpw_pkg::TPW_BUS_FETCH: begin
        s_d.bus = tpw_pkg::TPW_BUS_DONE;
        case (s_q.addr)
          tpw_pkg::IDX_CLK_SEL: val = 8'(s_q.clk_sel);
          tpw_pkg::IDX_CTRL: begin
            val = 8'(s_q.clr) | (8'(s_q.ch_ie) << tpw_pkg::CTRL_IE_LSB);
          end
          tpw_pkg::IDX_IRQ_EN: val = 8'(s_q.gie) << tpw_pkg::IRQ_EN_GLOBAL;
          tpw_pkg::IDX_FLAGS:  val = 8'(s_q.flags);
          default: begin
            for (int c = 0; c < CH_NUM; c++) begin
              base = tpw_pkg::IDX_CH_BASE + 8'(c) * tpw_pkg::CH_STRIDE;
              if (s_q.addr == base + tpw_pkg::OFS_DUTY_LO ||
                  s_q.addr == base + tpw_pkg::OFS_PER_LO) begin
                val = s_q.latch;
              end
              if (s_q.addr == base + tpw_pkg::OFS_DUTY_HI) begin
                val       = s_q.duty_sh[c][CNT_W-1 -: 8];
                s_d.latch = s_q.duty_sh[c][7:0];
              end
              if (s_q.addr == base + tpw_pkg::OFS_PER_HI) begin
                val       = s_q.per_sh[c][CNT_W-1 -: 8];
                s_d.latch = s_q.per_sh[c][7:0];
              end
            end
          end
        endcase
        s_d.rdata = val;
      end
      tpw_pkg::TPW_BUS_DONE: begin
        s_d.bus = tpw_pkg::TPW_BUS_IDLE;
      end
      default: begin
        s_d.bus = tpw_pkg::TPW_BUS_IDLE;
      end
    endcase

    // Address phase; only accepted while the bus is ready.
    if (take && s_q.bus != tpw_pkg::TPW_BUS_FETCH) begin
      // Addresses above the map decode to an index no register uses.
      s_d.addr    = (HADDR_IN[31:10] == 22'h000000) ? HADDR_IN[9:2] : 8'h00;
      s_d.wr_pend = HWRITE_IN;
      if (!HWRITE_IN) begin
        s_d.bus = tpw_pkg::TPW_BUS_FETCH;
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= TOP_RST;
    end else if (CE_IN) begin
      s_q <= s_d;
    end
  end

  // Channels only advance while the clock enable is high.
  for (genvar c = 0; c < CH_NUM; c++) begin : g_ch
    tpw_channel #(
      .CNT_W(CNT_W)
    ) u_ch (
      .clk_in         (SYS_CLK_IN),
      .rst_n_in       (rst_n),
      .ce_in          (CE_IN),
      .tick_in        (tick[c]),
      .clear_in       (s_q.clr[c]),
      .period_in      (s_q.per_sh[c]),
      .duty_in        (s_q.duty_sh[c]),
      .pwm_out        (pwm[c]),
      .period_end_out (period_end[c])
    );
  end

  assign PWM_OUT       = pwm;
  assign HRDATA_OUT    = {24'h000000, s_q.rdata};
  assign HREADYOUT_OUT = (s_q.bus != tpw_pkg::TPW_BUS_FETCH);
  assign HRESP_OUT     = 1'b0;
  assign IRQ_OUT       = s_q.gie & |(s_q.flags & s_q.ch_ie);

endmodule

`default_nettype wire

// ===== dv/tpw_checker.sv
// Bus, output and interrupt assertions for the triple modulator.
`timescale 1ns/100ps
`default_nettype none
module tpw_checker #(
  parameter int unsigned CH_NUM = 3
) (
  // Watched ports
  input wire logic              SYS_CLK_IN,
  input wire logic              RST_B_IN,
  input wire logic              HSEL_IN,
  input wire logic [31:0]       HADDR_IN,
  input wire logic [1:0]        HTRANS_IN,
  input wire logic              HWRITE_IN,
  input wire logic [31:0]       HWDATA_IN,
  input wire logic              HREADY_IN,
  input wire logic [31:0]       HRDATA_OUT,
  input wire logic              HREADYOUT_OUT,
  input wire logic [CH_NUM-1:0] PWM_OUT,
  input wire logic              IRQ_OUT
);
  logic              take;
  logic              wr_q;
  logic [7:0]        ix_q;
  logic [CH_NUM-1:0] clr_q;
  logic [CH_NUM-1:0] ie_q;
  logic              gie_q;
  assign take = HSEL_IN && HREADY_IN && HTRANS_IN[1];
  // Shadow copies of the control bits, tracked from completed writes.
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      wr_q <= 1'h0;
      ix_q <= 8'h00;
      clr_q <= '0;
      ie_q <= '0;
      gie_q <= 1'h0;
    end else begin
      wr_q <= take && HWRITE_IN;
      if (take) begin
        ix_q <= HADDR_IN[9:2];
      end
      if (wr_q && HREADY_IN && ix_q == tpw_pkg::IDX_CTRL) begin
        clr_q <= HWDATA_IN[CH_NUM-1:0];
        ie_q <= HWDATA_IN[4 +: CH_NUM];
      end
      if (wr_q && HREADY_IN && ix_q == tpw_pkg::IDX_IRQ_EN) begin
        gie_q <= HWDATA_IN[7];
      end
    end
  end
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  a_read_wait: assert property (take && !HWRITE_IN && HREADYOUT_OUT
    |=> !HREADYOUT_OUT ##1 HREADYOUT_OUT) else $error("read wait is not one cycle");
  a_write_nowait: assert property (take && HWRITE_IN |=> HREADYOUT_OUT)
    else $error("write stalled");
  a_wait_single: assert property (!HREADYOUT_OUT |=> HREADYOUT_OUT)
    else $error("wait longer than one cycle");
  a_rdata_hold: assert property (HREADYOUT_OUT && $past(HREADYOUT_OUT)
    |-> $stable(HRDATA_OUT)) else $error("read data moved");
  a_rdata_byte: assert property (HRDATA_OUT[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_clear_low: assert property ((clr_q & $past(clr_q, 2) & PWM_OUT) == '0)
    else $error("cleared channel output high");
  a_irq_gated: assert property (IRQ_OUT |-> gie_q && ie_q != '0)
    else $error("interrupt without enables");
  a_irq_sticky: assert property ($fell(IRQ_OUT) |-> $past(wr_q && HREADY_IN))
    else $error("interrupt fell without a write");
endmodule
bind tpw_triple_pwm tpw_checker #(.CH_NUM(CH_NUM)) u_chk (.*);
`default_nettype wire

// ===== dv/tpw_pin_meter.sv
// Pin load model: measures the last high and low run lengths of one output.
`timescale 1ns/100ps
`default_nettype none
module tpw_pin_meter (
  // Pin side
  input  wire logic        clk_in,
  input  wire logic        pin_in,
  // Measured runs in clock cycles
  output logic      [15:0] high_len_out,
  output logic      [15:0] low_len_out
);
  logic        last_q;
  logic [15:0] run_q;
  always_ff @(posedge clk_in) begin
    last_q <= pin_in;
    if (pin_in != last_q) begin
      run_q <= 16'h0001;
      if (last_q) begin
        high_len_out <= run_q;
      end else begin
        low_len_out <= run_q;
      end
    end else begin
      run_q <= run_q + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ===== dv/tpw_triple_pwm_tb.sv
// Self-checking bench for the triple modulator.
`timescale 1ns/100ps
`default_nettype none
module tpw_triple_pwm_tb;
  logic        SYS_CLK_IN = 1'h0;
  logic        RST_B_IN   = 1'h0;
  logic        CE_IN      = 1'h1;
  logic        HRESP_OUT;
  logic        FRC_CLK_IN = 1'h0;
  logic        HSEL_IN    = 1'h0;
  logic [31:0] HADDR_IN   = 32'h0;
  logic [1:0]  HTRANS_IN  = 2'h0;
  logic        HWRITE_IN  = 1'h0;
  logic [31:0] HWDATA_IN  = 32'h0;
  logic [31:0] HRDATA_OUT;
  logic        HREADYOUT_OUT;
  logic [2:0]  PWM_OUT;
  logic        IRQ_OUT;
  logic [15:0] hi_len [3];
  logic [15:0] lo_len [3];
  int          error_cnt    = 0;
  int          total_checks = 0;
  localparam logic [7:0] CTRL = tpw_pkg::IDX_CTRL;
  localparam logic [7:0] FLG  = tpw_pkg::IDX_FLAGS;
  localparam logic [7:0] GIE  = tpw_pkg::IDX_IRQ_EN;
  localparam logic [7:0] CKS  = tpw_pkg::IDX_CLK_SEL;
  localparam logic [7:0] DH   = tpw_pkg::OFS_DUTY_HI;
  localparam logic [7:0] PH   = tpw_pkg::OFS_PER_HI;
  always #5 SYS_CLK_IN = ~SYS_CLK_IN;
  // The oscillator pin runs free, 16 system cycles a period, toggling on falling clock edges.
  always #80 FRC_CLK_IN = ~FRC_CLK_IN;
  tpw_triple_pwm DUT (
    .SYS_CLK_IN(SYS_CLK_IN), .RST_B_IN(RST_B_IN), .CE_IN(CE_IN), .FRC_CLK_IN(FRC_CLK_IN),
    .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN),
    .HSIZE_IN(3'h2), .HWDATA_IN(HWDATA_IN), .HREADY_IN(HREADYOUT_OUT),
    .HRDATA_OUT(HRDATA_OUT), .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT),
    .PWM_OUT(PWM_OUT), .IRQ_OUT(IRQ_OUT));
  for (genvar i = 0; i < 3; i++) begin : g_meter
    tpw_pin_meter u_meter (.clk_in(SYS_CLK_IN), .pin_in(PWM_OUT[i]),
      .high_len_out(hi_len[i]), .low_len_out(lo_len[i]));
  end
  task automatic tally_and_finish;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ix, input logic [7:0] wd,
                     output logic [7:0] rd);
    HSEL_IN <= 1'h1;
    HTRANS_IN <= 2'h2;
    HWRITE_IN <= w;
    HADDR_IN <= {22'h0, ix, 2'h0};
    do @(posedge SYS_CLK_IN); while (HREADYOUT_OUT !== 1'h1);
    HSEL_IN <= 1'h0;
    HTRANS_IN <= 2'h0;
    HWDATA_IN <= {24'h0, wd};
    do @(posedge SYS_CLK_IN); while (HREADYOUT_OUT !== 1'h1);
    rd = HRDATA_OUT[7:0];
  endtask
  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    logic [7:0] rd;
    bus(1'h1, ix, d, rd);
  endtask
  task automatic rdc(input string nm, input logic [7:0] ix, input logic [7:0] exp);
    logic [7:0] rd;
    bus(1'h0, ix, 8'h00, rd);
    chk(nm, {8'h0, exp}, {8'h0, rd});
    chk("hresp", 16'h0000, {15'h0, HRESP_OUT});
  endtask
  function automatic logic [7:0] cx(input logic [7:0] c, input logic [7:0] o);
    return tpw_pkg::IDX_CH_BASE + tpw_pkg::CH_STRIDE * c + o;
  endfunction
  task automatic set16(input logic [7:0] c, input logic [7:0] hi, input logic [15:0] v);
    wr(cx(c, hi + 8'h01), v[7:0]);
    wr(cx(c, hi), v[15:8]);
  endtask
  task automatic irq_is(input string nm, input logic exp);
    @(posedge SYS_CLK_IN);
    chk(nm, {15'h0, exp}, {15'h0, IRQ_OUT});
  endtask
  task automatic t_reset;
    chk("pwm_reset", 16'h0007, {13'h0, PWM_OUT});
    rdc("clk_sel", CKS, 8'h2A);
    rdc("duty_hi", cx(0, DH), 8'h80);
    rdc("per_hi", cx(2, PH), 8'hFF);
    wr(8'h00, 8'h5A);
    rdc("unmapped", 8'h00, 8'h00);
  endtask
  task automatic t_latch;
    set16(1, DH, 16'h1234);
    wr(cx(0, PH + 8'h01), 8'h56);
    wr(cx(2, DH), 8'h9A);
    rdc("d1_hi", cx(1, DH), 8'h12);
    rdc("latch_shared", cx(2, DH + 8'h01), 8'h34);
    rdc("d1_lo", cx(1, DH + 8'h01), 8'h34);
    rdc("d2_hi", cx(2, DH), 8'h9A);
    rdc("d2_lo", cx(2, DH + 8'h01), 8'h56);
  endtask
  task automatic t_wave;
    logic [2:0] p;
    wr(CTRL, 8'h07);
    repeat (3) @(posedge SYS_CLK_IN);
    chk("cleared", 16'h0000, {13'h0, PWM_OUT});
    set16(0, PH, 16'h0003);
    set16(0, DH, 16'h0002);
    set16(1, PH, 16'h0004);
    set16(1, DH, 16'h0001);
    set16(2, PH, 16'h0001);
    set16(2, DH, 16'h0001);
    wr(CKS, 8'h24);
    wr(CTRL, 8'h00);
    // Channel 2 ticks every 16 cycles, so two full runs need about 70 cycles.
    repeat (100) @(posedge SYS_CLK_IN);
    chk("hi0", 16'h0002, hi_len[0]);
    chk("lo0", 16'h0002, lo_len[0]);
    chk("hi1", 16'h0001, hi_len[1]);
    chk("lo1", 16'h0004, lo_len[1]);
    chk("hi2", 16'h0010, hi_len[2]);
    chk("lo2", 16'h0010, lo_len[2]);
    wr(CKS, 8'h30);
    repeat (100) @(posedge SYS_CLK_IN);
    chk("hi1_sys", 16'h0001, hi_len[1]);
    chk("hi2_dbl", 16'h0008, hi_len[2]);
    chk("lo2_dbl", 16'h0008, lo_len[2]);
    // A low clock enable must freeze the toggling outputs.
    CE_IN <= 1'h0;
    repeat (2) @(posedge SYS_CLK_IN);
    p = PWM_OUT;
    repeat (20) @(posedge SYS_CLK_IN);
    chk("ce_hold", {13'h0, p}, {13'h0, PWM_OUT});
    CE_IN <= 1'h1;
    @(posedge SYS_CLK_IN);
  endtask
  task automatic t_irq;
    wr(CTRL, 8'h17);
    wr(FLG, 8'h00);
    wr(FLG, 8'h07);
    rdc("flags_one", FLG, 8'h00);
    wr(GIE, 8'h80);
    irq_is("irq_idle", 1'h0);
    wr(CTRL, 8'h10);
    repeat (40) @(posedge SYS_CLK_IN);
    rdc("flags_set", FLG, 8'h07);
    irq_is("irq_on", 1'h1);
    wr(GIE, 8'h00);
    irq_is("irq_masked", 1'h0);
    wr(CTRL, 8'h17);
    wr(GIE, 8'h80);
    irq_is("irq_sticky", 1'h1);
    wr(FLG, 8'h06);
    irq_is("irq_cleared", 1'h0);
    rdc("flags_left", FLG, 8'h06);
  endtask
  initial begin
    repeat (10) @(posedge SYS_CLK_IN);
    RST_B_IN <= 1'h1;
    repeat (3) @(posedge SYS_CLK_IN);
    t_reset;
    t_latch;
    t_wave;
    t_irq;
    tally_and_finish;
  end
  // The tests need well under a thousand cycles; a hang is cut off here.
  initial begin
    repeat (5000) @(posedge SYS_CLK_IN);
    error_cnt++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
